// ### wfpm_pkg.sv
// wfpm_pkg: constants, register map and carrier types of the wake frame matcher
package wfpm_pkg;
    // pattern and register geometry
    localparam int WFPM_NPAT = 3;
    localparam int WFPM_NREG = 6;
    localparam int WFPM_NMASK = 4;
    localparam int WFPM_REG_W = 16;
    localparam int WFPM_ADDR_W = 8;
    localparam int WFPM_WIN_BYTES = 64;
    localparam int WFPM_CNT_W = 7;
    // slots inside one pattern's register group
    localparam int WFPM_SLOT_CRC_LO = 0;
    localparam int WFPM_SLOT_CRC_HI = 1;
    localparam int WFPM_SLOT_MASK0 = 2;
    // byte positions where mask words 1 and 2 start, the last window byte, and the counter limit
    localparam logic [6:0] WFPM_MASK1_FIRST = 7'h10;
    localparam logic [6:0] WFPM_MASK2_FIRST = 7'h20;
    localparam logic [6:0] WFPM_MASK3_LAST = 7'h3F;
    localparam logic [6:0] WFPM_CNT_SAT = 7'h40;
    // pattern 1 registers
    localparam logic [7:0] WAKE_P1_CRC_LOW = 8'h40;
    localparam logic [7:0] WAKE_P1_CRC_HIGH = 8'h42;
    localparam logic [7:0] WAKE_P1_MASK_BYTES1_16 = 8'h44;
    localparam logic [7:0] WAKE_P1_MASK_BYTES17_32 = 8'h46;
    localparam logic [7:0] WAKE_P1_MASK_BYTES33_48 = 8'h48;
    localparam logic [7:0] WAKE_P1_MASK_BYTES49_64 = 8'h4A;
    // pattern 2 registers
    localparam logic [7:0] WAKE_P2_CRC_LOW = 8'h50;
    localparam logic [7:0] WAKE_P2_CRC_HIGH = 8'h52;
    localparam logic [7:0] WAKE_P2_MASK_BYTES1_16 = 8'h54;
    localparam logic [7:0] WAKE_P2_MASK_BYTES17_32 = 8'h56;
    localparam logic [7:0] WAKE_P2_MASK_BYTES33_48 = 8'h58;
    localparam logic [7:0] WAKE_P2_MASK_BYTES49_64 = 8'h5A;
    // pattern 3 registers
    localparam logic [7:0] WAKE_P3_CRC_LOW = 8'h60;
    localparam logic [7:0] WAKE_P3_CRC_HIGH = 8'h62;
    localparam logic [7:0] WAKE_P3_MASK_BYTES1_16 = 8'h64;
    localparam logic [7:0] WAKE_P3_MASK_BYTES17_32 = 8'h66;
    localparam logic [7:0] WAKE_P3_MASK_BYTES33_48 = 8'h68;
    localparam logic [7:0] WAKE_P3_MASK_BYTES49_64 = 8'h6A;
    // control, status and interrupt registers
    localparam logic [7:0] WAKE_PAT_ENABLE = 8'h80;
    localparam logic [7:0] WAKE_STATUS = 8'h82;
    localparam logic [7:0] WAKE_STATUS_CLEAR = 8'h84;
    localparam logic [7:0] WAKE_IRQ_ENABLE = 8'h86;
    // bit i of those registers belongs to pattern i+1
    localparam logic [15:0] WFPM_RESET_VAL = 16'h0000;
    localparam logic [2:0] WFPM_BITS_RESET = 3'h0;
    // address table indexed [pattern][slot]
    localparam logic [7:0] WFPM_MAP [WFPM_NPAT][WFPM_NREG] = '{
        '{WAKE_P1_CRC_LOW, WAKE_P1_CRC_HIGH, WAKE_P1_MASK_BYTES1_16,
          WAKE_P1_MASK_BYTES17_32, WAKE_P1_MASK_BYTES33_48, WAKE_P1_MASK_BYTES49_64},
        '{WAKE_P2_CRC_LOW, WAKE_P2_CRC_HIGH, WAKE_P2_MASK_BYTES1_16,
          WAKE_P2_MASK_BYTES17_32, WAKE_P2_MASK_BYTES33_48, WAKE_P2_MASK_BYTES49_64},
        '{WAKE_P3_CRC_LOW, WAKE_P3_CRC_HIGH, WAKE_P3_MASK_BYTES1_16,
          WAKE_P3_MASK_BYTES17_32, WAKE_P3_MASK_BYTES33_48, WAKE_P3_MASK_BYTES49_64}};
    // crc32 constants, reflected form
    localparam logic [31:0] WFPM_CRC_INIT = 32'hFFFFFFFF;
    localparam logic [31:0] WFPM_CRC_POLY = 32'hEDB88320;
    // one received byte with its frame marks
    typedef struct packed {
        logic sof;
        logic eof;
        logic [7:0] data;
    } wfpm_rx_t;
endpackage

// ### wfpm_crc.sv
// wfpm_crc: one running ethernet crc32 engine, byte at a time
`timescale 1ns/1ps
module wfpm_crc
    import wfpm_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // byte stream
    input wire logic valid,
    input wire logic start,
    input wire logic feed,
    input wire logic [7:0] data,
    // running remainder
    output logic [31:0] crc_next,
    output logic [31:0] crc_q
);
    logic [31:0] base; // remainder before this byte
    logic [31:0] upd; // remainder after folding this byte

    // frame start restarts from the preset value
    assign base = start ? WFPM_CRC_INIT : crc_q;

    // bitwise lsb-first division, unrolled by the loop
    always_comb begin
        upd = base ^ {24'h000000, data};
        for (int b = 0; b < 8; b++) begin
            upd = upd[0] ? ((upd >> 1) ^ WFPM_CRC_POLY) : (upd >> 1);
        end
    end

    // unselected bytes leave the remainder as is, except a frame start byte, which loads the preset
    assign crc_next = feed ? upd : base;

    // remainder only moves on valid bytes
    always_ff @(posedge clk) begin
        if (rst) begin
            crc_q <= WFPM_CRC_INIT;
        end else if (valid) begin
            crc_q <= crc_next;
        end
    end
endmodule // wfpm_crc

// ### wfpm_top.sv
// wfpm_top: wake frame pattern registers, matchers and interrupt
`timescale 1ns/1ps
module wfpm_top
    import wfpm_pkg::*;
#(
    parameter int NPAT = WFPM_NPAT
)
(
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RST,
    // register port
    input wire logic [WFPM_ADDR_W-1:0] ADDR,
    input wire logic [WFPM_REG_W-1:0] WR_DATA,
    input wire logic WR_STB,
    input wire logic RD_STB,
    output logic [WFPM_REG_W-1:0] RD_DATA,
    // receive byte stream from the mac
    input wire logic RX_VALID,
    input wire wfpm_rx_t RX_BYTE,
    // wake reporting
    output logic [NPAT-1:0] WAKE_EVENT,
    output logic IRQ
);
    // the map and bit fields are laid out for exactly three patterns
    if (NPAT != WFPM_NPAT) begin : g_bad_npat
        $error("wfpm_top: NPAT must equal the mapped pattern count");
    end

    logic [WFPM_REG_W-1:0] cfg_q [NPAT][WFPM_NREG]; // crc halves and masks
    logic [NPAT-1:0] pen_q; // pattern enables
    logic [NPAT-1:0] sts_q; // sticky wake status
    logic [NPAT-1:0] sts_d;
    logic [NPAT-1:0] ien_q; // interrupt enables
    logic [WFPM_REG_W-1:0] rd_q; // read return register
    logic [WFPM_REG_W-1:0] rd_d;
    logic [NPAT-1:0] wake_q; // one-cycle match pulses
    logic irq_q;
    logic [WFPM_CNT_W-1:0] cnt_q; // bytes seen so far, saturating
    logic [WFPM_CNT_W-1:0] cnt_eff; // position of the current byte
    logic in_win; // current byte lies in the first 64
    logic [NPAT-1:0] match; // frame end with matching crc
    logic [NPAT-1:0] feed; // current byte goes into pattern crc
    logic [31:0] crc_nx [NPAT]; // remainder including this byte
    logic [31:0] crc_r [NPAT]; // stored remainder
    logic [NPAT*WFPM_NREG-1:0] hit_flat; // config address decode
    logic hit_pen;
    logic hit_sts;
    logic hit_clr;
    logic hit_ien;
    logic [NPAT-1:0] clr_bits; // status bits cleared by this write

    // fixed-function register decode
    assign hit_pen = (ADDR == WAKE_PAT_ENABLE);
    assign hit_sts = (ADDR == WAKE_STATUS);
    assign hit_clr = (ADDR == WAKE_STATUS_CLEAR);
    assign hit_ien = (ADDR == WAKE_IRQ_ENABLE);
    assign clr_bits = (WR_STB && hit_clr) ? WR_DATA[NPAT-1:0] : WFPM_BITS_RESET;

    // byte position: a start-of-frame byte is always byte one
    assign cnt_eff = (RX_BYTE.sof) ? '0 : cnt_q;
    assign in_win = (cnt_eff < WFPM_CNT_SAT);

    // frame byte counter, stops at 64 so later bytes are never selected
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            cnt_q <= '0;
        end else if (RX_VALID) begin
            cnt_q <= in_win ? cnt_eff + 7'h01 : WFPM_CNT_SAT;
        end
    end

    // per-pattern register storage, mask selection and crc engine
    for (genvar p = 0; p < NPAT; p++) begin : g_pat
        logic [4*WFPM_REG_W-1:0] mask64; // bit n selects byte n+1
        logic [31:0] expect_crc; // programmed expected crc

        // mask words concatenated so byte position indexes directly
        assign mask64 = {cfg_q[p][WFPM_SLOT_MASK0+3],
                         cfg_q[p][WFPM_SLOT_MASK0+2],
                         cfg_q[p][WFPM_SLOT_MASK0+1],
                         cfg_q[p][WFPM_SLOT_MASK0]};
        // halves joined, low register in bits 15..0
        assign expect_crc = {cfg_q[p][WFPM_SLOT_CRC_HI],
                             cfg_q[p][WFPM_SLOT_CRC_LO]};

        // only selected in-window bytes feed the crc
        assign feed[p] = RX_VALID && in_win && mask64[cnt_eff[5:0]];

        // final complement turns the remainder into the frame crc
        assign match[p] = RX_VALID && RX_BYTE.eof && pen_q[p]
                          && (~crc_nx[p] == expect_crc);

        wfpm_crc u_crc (
            .clk(SYS_CLK),
            .rst(RST),
            .valid(RX_VALID),
            .start(RX_BYTE.sof),
            .feed(feed[p]),
            .data(RX_BYTE.data),
            .crc_next(crc_nx[p]),
            .crc_q(crc_r[p])
        );

        for (genvar r = 0; r < WFPM_NREG; r++) begin : g_reg
            // address match for one config word
            assign hit_flat[p*WFPM_NREG+r] = (ADDR == WFPM_MAP[p][r]);

            // plain read/write storage
            always_ff @(posedge SYS_CLK) begin
                if (RST) begin
                    cfg_q[p][r] <= WFPM_RESET_VAL;
                end else if (WR_STB && hit_flat[p*WFPM_NREG+r]) begin
                    cfg_q[p][r] <= WR_DATA;
                end
            end
        end
    end

    // set beats clear so a match in the clearing cycle is kept
    assign sts_d = (sts_q & ~clr_bits) | match;

    // read mux; unmapped and write-only addresses read as zero
    always_comb begin
        rd_d = '0;
        for (int p = 0; p < NPAT; p++) begin
            for (int r = 0; r < WFPM_NREG; r++) begin
                if (hit_flat[p*WFPM_NREG+r]) begin
                    rd_d = cfg_q[p][r];
                end
            end
        end
        if (hit_pen) begin
            rd_d = {{(WFPM_REG_W-NPAT){1'b0}}, pen_q};
        end
        if (hit_sts) begin
            rd_d = {{(WFPM_REG_W-NPAT){1'b0}}, sts_q};
        end
        if (hit_ien) begin
            rd_d = {{(WFPM_REG_W-NPAT){1'b0}}, ien_q};
        end
    end

    // control registers written by software
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            pen_q <= WFPM_BITS_RESET;
            ien_q <= WFPM_BITS_RESET;
        end else if (WR_STB) begin
            if (hit_pen) begin
                pen_q <= WR_DATA[NPAT-1:0];
            end
            if (hit_ien) begin
                ien_q <= WR_DATA[NPAT-1:0];
            end
        end
    end

    // status, pulses, interrupt and read return
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            sts_q <= WFPM_BITS_RESET;
            wake_q <= WFPM_BITS_RESET;
            irq_q <= 1'b0;
            rd_q <= WFPM_RESET_VAL;
        end else begin
            sts_q <= sts_d;
            wake_q <= match;
            // level from next status so it follows in the same edge
            irq_q <= |(sts_d & ien_q);
            // data stands only in the cycle after the strobe
            rd_q <= RD_STB ? rd_d : WFPM_RESET_VAL;
        end
    end

    // outputs straight from flops
    assign RD_DATA = rd_q;
    assign WAKE_EVENT = wake_q;
    assign IRQ = irq_q;

    // byte one is chosen by bit 0 of the first mask word
    a_mask_first_byte: assert property (@(posedge SYS_CLK) disable iff (RST)
        RX_VALID && RX_BYTE.sof |-> feed[0] == cfg_q[0][WFPM_SLOT_MASK0][0])
        else $error("first byte not selected by mask word 0 bit 0");

    // byte 17 is chosen by bit 0 of the second mask word
    a_mask_byte_17: assert property (@(posedge SYS_CLK) disable iff (RST)
        RX_VALID && !RX_BYTE.sof && cnt_q == WFPM_MASK1_FIRST
        |-> feed[1] == cfg_q[1][WFPM_SLOT_MASK0+1][0])
        else $error("byte 17 not selected by mask word 1 bit 0");

    // byte 33 is chosen by bit 0 of the third mask word
    a_mask_byte_33: assert property (@(posedge SYS_CLK) disable iff (RST)
        RX_VALID && !RX_BYTE.sof && cnt_q == WFPM_MASK2_FIRST
        |-> feed[2] == cfg_q[2][WFPM_SLOT_MASK0+2][0])
        else $error("byte 33 not selected by mask word 2 bit 0");

    // byte 64 is chosen by bit 15 of the fourth mask word
    a_mask_byte_64: assert property (@(posedge SYS_CLK) disable iff (RST)
        RX_VALID && !RX_BYTE.sof && cnt_q == WFPM_MASK3_LAST
        |-> feed[0] == cfg_q[0][WFPM_SLOT_MASK0+3][15])
        else $error("byte 64 not selected by mask word 3 bit 15");

    // bytes past the window never move the remainder
    a_crc_window_end: assert property (@(posedge SYS_CLK) disable iff (RST)
        RX_VALID && !RX_BYTE.sof && cnt_q == WFPM_CNT_SAT
        |=> crc_r[1] == $past(crc_r[1]))
        else $error("crc moved on a byte beyond the window");

    // low crc write lands in the low half only
    a_crc_low_write: assert property (@(posedge SYS_CLK) disable iff (RST)
        WR_STB && ADDR == WAKE_P2_CRC_LOW
        |=> g_pat[1].expect_crc[15:0] == $past(WR_DATA)
            && g_pat[1].expect_crc[31:16] == $past(g_pat[1].expect_crc[31:16]))
        else $error("crc low write misplaced");

    // high crc write lands in the high half and reads back
    a_crc_high_read: assert property (@(posedge SYS_CLK) disable iff (RST)
        WR_STB && ADDR == WAKE_P3_CRC_HIGH ##1 RD_STB && ADDR == WAKE_P3_CRC_HIGH
        |=> RD_DATA == g_pat[2].expect_crc[31:16])
        else $error("crc high readback wrong");

    // no wake pulse from a disabled pattern
    a_wake_needs_en: assert property (@(posedge SYS_CLK) disable iff (RST)
        |WAKE_EVENT |-> ($past(pen_q) & WAKE_EVENT) == WAKE_EVENT)
        else $error("wake pulse from disabled pattern");

    // a wake pulse only follows an end byte with equal crc
    a_wake_crc_eq: assert property (@(posedge SYS_CLK) disable iff (RST)
        WAKE_EVENT[2] |-> $past(RX_VALID) && $past(RX_BYTE.eof)
            && ~$past(crc_nx[2]) == $past(g_pat[2].expect_crc))
        else $error("wake pulse without crc match");

    // a wake pulse leaves its status bit set
    a_wake_sets_sts: assert property (@(posedge SYS_CLK) disable iff (RST)
        WAKE_EVENT[0] |-> sts_q[0] ##1 (sts_q[0] || $past(clr_bits[0])))
        else $error("wake pulse did not set sticky status");

    // byte 16 is chosen by bit 15 of the first mask word
    a_mask_byte_16: assert property (@(posedge SYS_CLK) disable iff (RST)
        RX_VALID && !RX_BYTE.sof && cnt_q == WFPM_MASK1_FIRST - 7'h01
        |-> feed[1] == cfg_q[1][WFPM_SLOT_MASK0][15])
        else $error("byte 16 not selected by mask word 0 bit 15");

    // byte 32 is chosen by bit 15 of the second mask word
    a_mask_byte_32: assert property (@(posedge SYS_CLK) disable iff (RST)
        RX_VALID && !RX_BYTE.sof && cnt_q == WFPM_MASK2_FIRST - 7'h01
        |-> feed[2] == cfg_q[2][WFPM_SLOT_MASK0+1][15])
        else $error("byte 32 not selected by mask word 1 bit 15");

    // byte 48 sits at position 63 less 16, bit 15 of the third mask word
    a_mask_byte_48: assert property (@(posedge SYS_CLK) disable iff (RST)
        RX_VALID && !RX_BYTE.sof && cnt_q == WFPM_MASK3_LAST - WFPM_MASK1_FIRST
        |-> feed[0] == cfg_q[0][WFPM_SLOT_MASK0+2][15])
        else $error("byte 48 not selected by mask word 2 bit 15");

    // byte 49 sits at position 32 plus 16, bit 0 of the fourth mask word
    a_mask_byte_49: assert property (@(posedge SYS_CLK) disable iff (RST)
        RX_VALID && !RX_BYTE.sof && cnt_q == WFPM_MASK2_FIRST + WFPM_MASK1_FIRST
        |-> feed[1] == cfg_q[1][WFPM_SLOT_MASK0+3][0])
        else $error("byte 49 not selected by mask word 3 bit 0");

    // a byte left out by the mask leaves the remainder as it was
    a_unfed_crc_hold: assert property (@(posedge SYS_CLK) disable iff (RST)
        RX_VALID && !RX_BYTE.sof && !feed[2] |=> crc_r[2] == $past(crc_r[2]))
        else $error("crc moved on an unselected byte");

    // a frame start reloads the preset even when its byte is skipped
    a_sof_preset: assert property (@(posedge SYS_CLK) disable iff (RST)
        RX_VALID && RX_BYTE.sof && !feed[0] |=> crc_r[0] == WFPM_CRC_INIT)
        else $error("frame start did not reload the crc preset");

    // the enable register keeps the written pattern bits
    a_enable_write: assert property (@(posedge SYS_CLK) disable iff (RST)
        WR_STB && ADDR == WAKE_PAT_ENABLE |=> pen_q == $past(WR_DATA[NPAT-1:0]))
        else $error("pattern enable write lost");

    // a clear with no match in its cycle empties the named bits
    a_status_clear: assert property (@(posedge SYS_CLK) disable iff (RST)
        WR_STB && ADDR == WAKE_STATUS_CLEAR && match == WFPM_BITS_RESET
        |=> (sts_q & $past(WR_DATA[NPAT-1:0])) == WFPM_BITS_RESET)
        else $error("status clear left a bit set");

    // a set status bit stays until a clear names it
    a_status_sticky: assert property (@(posedge SYS_CLK) disable iff (RST)
        sts_q[1] && !clr_bits[1] |=> sts_q[1])
        else $error("status bit dropped without a clear");

    // the interrupt follows enabled status, the enable taken one edge late
    a_irq_level: assert property (@(posedge SYS_CLK) disable iff (RST)
        IRQ == (|(sts_q & $past(ien_q))))
        else $error("interrupt level disagrees with enabled status");

    // status reads back as it stood in the strobe cycle
    a_status_read: assert property (@(posedge SYS_CLK) disable iff (RST)
        RD_STB && ADDR == WAKE_STATUS |=> RD_DATA[NPAT-1:0] == $past(sts_q))
        else $error("status readback wrong");

    // read data stand for one cycle only, zero otherwise
    a_rd_idle: assert property (@(posedge SYS_CLK) disable iff (RST)
        !RD_STB |=> RD_DATA == WFPM_RESET_VAL)
        else $error("read data outside the answer cycle");
endmodule // wfpm_top

// ### wfpm_mac_model.sv
// wfpm_mac_model: behavioural mac receive path feeding frame bytes
`timescale 1ns/1ps
module wfpm_mac_model
    import wfpm_pkg::*;
(
    // clock
    input wire logic clk,
    // byte stream towards the matcher
    output logic rx_valid,
    output wfpm_rx_t rx_byte
);
    // fixed frame contents, distinct per position so a shifted mask shows
    function automatic logic [7:0] byte_at(input int n);
        return 8'(n * 37 + 5);
    endfunction

    // idle at time zero
    initial begin
        rx_valid = 1'b0;
        rx_byte = '0;
    end

    // one frame, sof on byte 1 and eof on the last; optional idle gaps
    task automatic send_frame(input int len, input bit gap);
        for (int n = 1; n <= len; n++) begin
            rx_valid <= 1'b1;
            rx_byte <= {n == 1, n == len, byte_at(n)};
            @(posedge clk);
            // gap cycle: data scrambled so a stale byte cannot pass for a real one
            if (gap && n < len) begin
                rx_valid <= 1'b0;
                rx_byte.data <= ~byte_at(n);
                @(posedge clk);
            end
        end
        // released line shows the inverse, never the last value
        rx_valid <= 1'b0;
        rx_byte <= {1'b0, 1'b0, ~byte_at(len)};
    endtask
endmodule // wfpm_mac_model

// ### wfpm_top_tb.sv
// wfpm_top_tb: self-checking bench of the wake frame matcher
`timescale 1ns/1ps
module wfpm_top_tb;
    import wfpm_pkg::*;
    // one table case: pattern, 64-bit mask, frame length, crc right, gaps
    typedef struct packed {
        logic [1:0] pat;
        logic [63:0] mask;
        logic [6:0] len;
        logic good;
        logic gap;
    } wfpm_row_t;
    localparam int NROW = 7;
    // mask edges of every word, bytes past 64, and a wrong crc
    localparam wfpm_row_t ROWS [NROW] = '{
        '{2'h0, 64'h0000_0000_0000_0001, 7'h10, 1'b1, 1'b0},
        '{2'h1, 64'h0000_0000_0000_8000, 7'h10, 1'b1, 1'b1},
        '{2'h2, 64'h0000_0000_8001_0000, 7'h20, 1'b1, 1'b0},
        '{2'h0, 64'h0000_8001_0000_0000, 7'h30, 1'b1, 1'b0},
        '{2'h1, 64'h8001_0000_0000_0000, 7'h40, 1'b1, 1'b0},
        '{2'h2, 64'h8000_0000_0000_0000, 7'h48, 1'b1, 1'b1},
        '{2'h2, 64'h0000_0000_0000_F00F, 7'h14, 1'b0, 1'b0}};
    // design signals, every design input given a value at time zero
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [15:0] wr_data = 16'h0000;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic [15:0] rd_data;
    logic rx_valid;
    wfpm_rx_t rx_byte;
    logic [2:0] wake_event;
    logic irq;
    // score keeping
    int err_total = 0;
    int num_checks = 0;
    logic [15:0] d;
    logic [31:0] c;

    // 100 MHz clock
    always #5 sys_clk = ~sys_clk;

    wfpm_mac_model mac_model_inst (.clk(sys_clk), .rx_valid(rx_valid), .rx_byte(rx_byte));
    wfpm_top #(.NPAT(3)) wfpm_top_inst (
        .SYS_CLK(sys_clk), .RST(rst), .ADDR(addr), .WR_DATA(wr_data), .WR_STB(wr_stb),
        .RD_STB(rd_stb), .RD_DATA(rd_data), .RX_VALID(rx_valid), .RX_BYTE(rx_byte),
        .WAKE_EVENT(wake_event), .IRQ(irq));

    // own crc32 reference, reflected, over selected bytes within 64
    function automatic logic [31:0] exp_crc(input logic [63:0] m, input int len);
        logic [31:0] r;
        r = WFPM_CRC_INIT;
        for (int n = 1; n <= len && n <= 64; n++) begin
            if (m[n-1]) begin
                r = r ^ {24'h0, mac_model_inst.byte_at(n)};
                for (int k = 0; k < 8; k++) r = r[0] ? (r >> 1) ^ WFPM_CRC_POLY : r >> 1;
            end
        end
        return ~r;
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // write: one strobe cycle, then a quiet cycle so strobes never collide
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        addr <= a;
        wr_data <= v;
        wr_stb <= 1'b1;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
        @(posedge sys_clk);
    endtask

    // read: data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        #1 v = rd_data;
        @(posedge sys_clk);
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // hang guard, well beyond the few hundred cycles the run needs
    initial begin
        #500000;
        err_total++;
        wrap_up();
    end

    // main sequence
    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        // reset values of the whole map
        for (int p = 0; p < 3; p++) begin
            for (int s = 0; s < 6; s++) begin
                rd(WFPM_MAP[p][s], d);
                chk(d, 16'h0000);
            end
        end
        // table cases: program crc and masks, enable one pattern, send frame
        for (int i = 0; i < NROW; i++) begin
            c = exp_crc(ROWS[i].mask, int'(ROWS[i].len)) ^ {31'h0, ~ROWS[i].good};
            wr(WFPM_MAP[ROWS[i].pat][0], c[15:0]);
            wr(WFPM_MAP[ROWS[i].pat][1], c[31:16]);
            for (int w = 0; w < 4; w++) wr(WFPM_MAP[ROWS[i].pat][2+w], ROWS[i].mask[16*w +: 16]);
            rd(WFPM_MAP[ROWS[i].pat][0], d);
            chk(d, c[15:0]);
            rd(WFPM_MAP[ROWS[i].pat][1], d);
            chk(d, c[31:16]);
            wr(WAKE_PAT_ENABLE, 16'h0001 << ROWS[i].pat);
            d = ROWS[i].good ? 16'h0001 << ROWS[i].pat : 16'h0000;
            mac_model_inst.send_frame(int'(ROWS[i].len), ROWS[i].gap);
            #1 chk({13'h0, wake_event}, d);
            @(posedge sys_clk);
        end
        // all-zero masks with expected zero match any frame; irq masked first
        wr(WAKE_IRQ_ENABLE, 16'h0000);
        wr(WAKE_STATUS_CLEAR, 16'h0007);
        for (int s = 0; s < 6; s++) wr(WFPM_MAP[1][s], 16'h0000);
        wr(WAKE_PAT_ENABLE, 16'h0002);
        mac_model_inst.send_frame(10, 1'b0);
        #1 chk({13'h0, wake_event}, 16'h0002);
        chk({15'h0, irq}, 16'h0000);
        @(posedge sys_clk);
        #1 chk({13'h0, wake_event}, 16'h0000);
        @(posedge sys_clk);
        // status is sticky and ignores writes
        wr(WAKE_STATUS, 16'h0000);
        rd(WAKE_STATUS, d);
        chk(d, 16'h0002);
        wr(WAKE_IRQ_ENABLE, 16'h0002);
        #1 chk({15'h0, irq}, 16'h0001);
        @(posedge sys_clk);
        wr(WAKE_STATUS_CLEAR, 16'h0002);
        #1 chk({15'h0, irq}, 16'h0000);
        @(posedge sys_clk);
        rd(WAKE_STATUS, d);
        chk(d, 16'h0000);
        // disabled pattern stays silent on a frame it would match
        wr(WAKE_PAT_ENABLE, 16'h0000);
        mac_model_inst.send_frame(10, 1'b0);
        #1 chk({13'h0, wake_event}, 16'h0000);
        @(posedge sys_clk);
        // unused enable bits and an unmapped offset read as zero
        wr(WAKE_PAT_ENABLE, 16'hFFFF);
        rd(WAKE_PAT_ENABLE, d);
        chk(d, 16'h0007);
        wr(8'h4C, 16'hBEEF);
        rd(8'h4C, d);
        chk(d, 16'h0000);
        #1 chk(rd_data, 16'h0000);
        @(posedge sys_clk);
        // write then read with no gap between the strobes
        addr <= WAKE_P3_CRC_HIGH;
        wr_data <= 16'hA55A;
        wr_stb <= 1'b1;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
        rd_stb <= 1'b1;
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        #1 chk(rd_data, 16'hA55A);
        @(posedge sys_clk);
        // clear in the very cycle of a match: the new event wins
        wr(WAKE_PAT_ENABLE, 16'h0002);
        wr(WAKE_IRQ_ENABLE, 16'h0002);
        fork
            mac_model_inst.send_frame(6, 1'b0);
            begin
                repeat (5) @(posedge sys_clk);
                addr <= WAKE_STATUS_CLEAR;
                wr_data <= 16'h0002;
                wr_stb <= 1'b1;
                @(posedge sys_clk);
                wr_stb <= 1'b0;
            end
        join
        #1 chk({13'h0, wake_event}, 16'h0002);
        chk({15'h0, irq}, 16'h0001);
        @(posedge sys_clk);
        rd(WAKE_STATUS, d);
        chk(d, 16'h0002);
        // reset in mid-run: outputs drop at once, registers read back zero
        rst <= 1'b1;
        @(posedge sys_clk);
        #1 chk({14'h0, irq, |wake_event}, 16'h0000);
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rd(WAKE_STATUS, d);
        chk(d, 16'h0000);
        rd(WAKE_PAT_ENABLE, d);
        chk(d, 16'h0000);
        rd(WAKE_P3_CRC_HIGH, d);
        chk(d, 16'h0000);
        // cleared map matches any frame once its enable is set
        wr(WAKE_PAT_ENABLE, 16'h0004);
        mac_model_inst.send_frame(5, 1'b1);
        #1 chk({13'h0, wake_event}, 16'h0004);
        wrap_up();
    end
endmodule // wfpm_top_tb
